/* mstim_core.sv */
// Status, flag latching, interrupt and select gating of a pluggable module.
// Assumes a bus engine on the link clock reports finished transactions and
// reads o_flags and o_bus_respond through its own synchronisers.
`timescale 1ns/10ps
`default_nettype none
`include "mstim_defines.svh"

// Summary of operation
// - Bus answers within 2000 ms of power on
// - Data-not-ready clears, interrupt asserts within 2000 ms
// - Fully functional within 2000 ms after reset release
// - Low-power pin takes effect within 100 us
// - Interrupt asserts within 200 ms of condition
// - Interrupt releases within 500 us of read
// - Receive loss flag and interrupt within 100 ms
// - Transmit fault flag and interrupt within 200 ms
// - Other flags and interrupt within 200 ms
// - Set mask inhibits source within 100 ms
// - Cleared mask resumes source within 100 ms
// - Select asserted: bus answers within 100 us
// - Select deasserted: bus silent within 100 us
// - Power-down bit gives low power within 100 ms
// - Power-down cleared: functional within 300 ms
// - Functional means interrupt from data-ready
// - Read timing starts at falling edge after stop
// - Write timing starts at falling edge after stop
module mstim_core
  import mstim_pkg::*;
#(
  parameter int P_OTHER = `MSTIM_OTHER_FLAGS,
  parameter int P_INIT_CYC = `MSTIM_INIT_CYC
) (
  input wire logic i_core_clk, // Core clock, 100 MHz
  input wire logic i_nrst, // Power-on reset, active low
  input wire logic i_link_clk, // Two-wire bus clock
  input wire logic i_link_stop, // Stop bit seen, link domain
  input wire logic i_link_rd_flags, // Transaction read the flags
  input wire logic i_link_wr_ctrl, // Transaction wrote controls
  input wire logic [`MSTIM_OTH_LSB+P_OTHER-1:0] i_link_mask, // Mask data
  input wire logic i_link_pdown, // Power-down data
  input wire logic i_module_reset_in_n, // Reset pin, active low
  input wire logic i_low_power_request, // Low-power pin
  input wire logic i_module_select_n, // Select pin, active low
  input wire logic [`MSTIM_LANES-1:0] i_rx_los, // Receive loss per lane
  input wire logic [`MSTIM_LANES-1:0] i_tx_fault, // Transmit fault per lane
  input wire logic [P_OTHER-1:0] i_other_flag, // Other conditions
  output logic o_interrupt_out_n_out, // Open-drain value, always low
  output logic o_interrupt_out_n_oe_n, // Low while pulling interrupt low
  output logic o_data_not_ready, // Status byte 2 bit 0
  output logic [`MSTIM_OTH_LSB+P_OTHER-1:0] o_flags, // Latched flags
  output logic o_init_flag, // Latched data-ready event
  output logic o_bus_respond, // Bus engine may answer
  output logic o_low_power, // Lower power level request
  output logic o_fully_functional // Ready and not in low power
);
  localparam int NF = `MSTIM_OTH_LSB + P_OTHER;
  localparam int NS = 3 + 2 + NF;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    mstim_state_e st;
    logic [31:0] cnt;
    logic dnr;
    logic init_fl;
    logic [NF-1:0] flags;
    logic [NF-1:0] mask;
    logic pdown;
    logic rd_seen;
    logic wr_seen;
    logic int_n;
    logic bus;
    logic lowp;
  } mstim_core_s;

  mstim_core_s q, n;
  logic [NF-1:0] l_mask;
  logic l_pdown;
  logic l_rd_tgl;
  logic l_wr_tgl;
  logic [NS-1:0] s_in;
  logic [NS-1:0] s_out;
  logic mrst_n;
  logic lp_req;
  logic sel_n;
  logic rd_tgl;
  logic wr_tgl;
  logic [NF-1:0] cond;
  logic rd_ev;
  logic wr_ev;

  // --------------------------------------------------------------------------
  // Link side and crossings
  // --------------------------------------------------------------------------
  // Transaction ends are captured on the falling bus clock
  mstim_link #(
    .NF(NF)
  ) mstim_link_i (
    .i_link_clk(i_link_clk),
    .i_nrst(i_nrst),
    .i_link_stop(i_link_stop),
    .i_link_rd_flags(i_link_rd_flags),
    .i_link_wr_ctrl(i_link_wr_ctrl),
    .i_link_mask(i_link_mask),
    .i_link_pdown(i_link_pdown),
    .o_rd_tgl(l_rd_tgl),
    .o_wr_tgl(l_wr_tgl),
    .o_mask(l_mask),
    .o_pdown(l_pdown)
  );

  // Pins and link toggles pass two flip-flops
  assign s_in = {i_module_reset_in_n, i_low_power_request, i_module_select_n,
                 l_rd_tgl, l_wr_tgl, i_other_flag, i_tx_fault, i_rx_los};

  mstim_sync #(
    .W(NS)
  ) mstim_sync_i (
    .i_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_d(s_in),
    .o_q(s_out)
  );

  assign {mrst_n, lp_req, sel_n, rd_tgl, wr_tgl, cond} = s_out;
  // Toggle edges mark finished reads and writes
  assign rd_ev = rd_tgl ^ q.rd_seen;
  assign wr_ev = wr_tgl ^ q.wr_seen;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    n = q;
    n.rd_seen = rd_tgl;
    n.wr_seen = wr_tgl;
    // Link data is stable once its toggle has crossed
    if (wr_ev) begin
      n.mask = l_mask;
      n.pdown = l_pdown;
    end
    // Clearing read first, then new conditions, so a set wins
    if (rd_ev) begin
      n.flags = '0;
      n.init_fl = 1'b0;
    end
    n.flags = n.flags | cond;
    unique case (q.st)
      MSTIM_ST_RESET: begin
        n.cnt = '0;
        n.dnr = 1'b1;
        if (mrst_n) begin
          n.st = MSTIM_ST_INIT;
        end
      end
      MSTIM_ST_INIT: begin
        n.cnt = q.cnt + 32'h1;
        if (q.cnt >= 32'(P_INIT_CYC - 1)) begin
          n.st = MSTIM_ST_RUN;
          n.dnr = 1'b0;
          n.init_fl = 1'b1;
        end
      end
      MSTIM_ST_RUN: begin
        n.cnt = q.cnt;
      end
      default: begin
        n.st = MSTIM_ST_RESET;
      end
    endcase
    // Reset pin held low restarts initialisation
    if (!mrst_n) begin
      n.st = MSTIM_ST_RESET;
      n.dnr = 1'b1;
      n.init_fl = 1'b0;
    end
    // Interrupt from unmasked flags or the data-ready event
    n.int_n = ~(|(n.flags & ~n.mask) | n.init_fl);
    n.bus = (n.st == MSTIM_ST_RUN) && !sel_n;
    n.lowp = lp_req | n.pdown;
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '{st: MSTIM_ST_RESET, cnt: 32'h0, dnr: 1'b1, int_n: 1'b1,
             default: '0};
    end else begin
      q <= n;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign o_interrupt_out_n_out = 1'b0;
  assign o_interrupt_out_n_oe_n = q.int_n;
  assign o_data_not_ready = q.dnr;
  assign o_flags = q.flags;
  assign o_init_flag = q.init_fl;
  assign o_bus_respond = q.bus;
  assign o_low_power = q.lowp;
  // Functional once ready and out of low power (pin and power-down bit)
  assign o_fully_functional = (q.st == MSTIM_ST_RUN) && !q.lowp;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  // Low-power, transmit fault and select antecedents use the raw pins, latencies include both sync stages; the others use synced levels or l_mask
  logic [2:0] lp_cnt;

  // Cycles since the low-power pin rose, saturating
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lp_cnt <= 3'h7;
    end else if (i_low_power_request && lp_cnt == 3'h7 && !o_low_power) begin
      lp_cnt <= 3'h0;
    end else if (lp_cnt != 3'h7) begin
      lp_cnt <= lp_cnt + 3'h1;
    end
  end

  lp_pin_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $rose(i_low_power_request) |-> ##[1:4] o_low_power)
    else $error("low-power pin not honoured in time");

  lp_count_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (lp_cnt == 3'h4) |-> (o_low_power || !i_low_power_request))
    else $error("low-power level late");

  los_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $rose(cond[`MSTIM_LOS_LSB]) |=> o_flags[`MSTIM_LOS_LSB] &&
      (q.mask[`MSTIM_LOS_LSB] || !o_interrupt_out_n_oe_n))
    else $error("receive loss flag or interrupt missing");

  txf_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $rose(i_tx_fault[0]) |-> ##[3:4] o_flags[`MSTIM_TXF_LSB])
    else $error("transmit fault flag missing");

  flag_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (o_flags[`MSTIM_OTH_LSB] && !rd_ev) |=> o_flags[`MSTIM_OTH_LSB])
    else $error("flag dropped without a read");

  int_release_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (rd_ev && cond == '0 && q.st != MSTIM_ST_INIT) |=> o_interrupt_out_n_oe_n)
    else $error("interrupt not released after clearing read");

  mask_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (q.mask == '1 && !q.init_fl) |-> o_interrupt_out_n_oe_n)
    else $error("masked source drove the interrupt");

  int_assert_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (|(q.flags & ~q.mask)) |-> !o_interrupt_out_n_oe_n)
    else $error("pending flag without interrupt");

  ready_int_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $fell(o_data_not_ready) |-> !o_interrupt_out_n_oe_n && o_init_flag)
    else $error("data-ready without interrupt");

  init_time_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (q.st == MSTIM_ST_INIT) |-> (q.cnt < 32'(P_INIT_CYC)) && o_data_not_ready)
    else $error("initialisation overran its limit");

  sel_on_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    ($fell(i_module_select_n) && q.st == MSTIM_ST_RUN && mrst_n)
      |-> ##[2:4] o_bus_respond)
    else $error("bus not answering after select");

  sel_off_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $rose(i_module_select_n) |-> ##[1:4] !o_bus_respond)
    else $error("bus still answering after deselect");

  modrst_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !mrst_n |=> (q.st == MSTIM_ST_RESET) && o_data_not_ready && !o_bus_respond)
    else $error("reset pin not honoured");

  pdown_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    q.pdown |-> o_low_power && !o_fully_functional)
    else $error("power-down bit without low power");

  oth_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $rose(cond[NF-1]) |=> o_flags[NF-1] && (q.mask[NF-1] || !o_interrupt_out_n_oe_n))
    else $error("other flag or interrupt missing");

  unmask_int_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (wr_ev && !rd_ev && |(q.flags & ~l_mask)) |=> !o_interrupt_out_n_oe_n)
    else $error("cleared mask did not resume the interrupt");

  // Cover points for the main scenarios
  ready_c: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
    $fell(o_data_not_ready));
  clear_c: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
    rd_ev && !o_interrupt_out_n_oe_n);
  write_c: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
    wr_ev && l_pdown);
  select_c: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
    $rose(o_bus_respond));
  mask_c: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
    (q.mask != '0) && (q.flags != '0) && o_interrupt_out_n_oe_n);
endmodule
`default_nettype wire

/* mstim_core_test.sv */
// Self-checking bench for mstim_core with a short init count.
// Assumes mstim_host drives the link side; fixed 3-4 cycle pin latencies.
`timescale 1ns/10ps
`default_nettype none
module mstim_core_test;
  localparam int NF = 12;
  localparam int INIT = 20;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic rst_pin_n = 1'b1;
  logic lp = 1'b0;
  logic sel_n = 1'b0;
  logic [NF-1:0] cond = '0;
  logic lclk, stop, rdf, wrc, pdn, int_out, oe_n, dnr, init_f, bus, low_pw, ff;
  logic [NF-1:0] lmask, flags;
  int fails = 0;
  int compares = 0;

  // ----------------------------------------
  // Clock, host model and design
  // ----------------------------------------
  always #5 clk = ~clk;
  mstim_host #(.NF(NF)) mstim_host_i (.o_link_clk(lclk), .o_link_stop(stop),
    .o_link_rd_flags(rdf), .o_link_wr_ctrl(wrc), .o_link_mask(lmask), .o_link_pdown(pdn));
  mstim_core #(.P_OTHER(4), .P_INIT_CYC(INIT)) mstim_core_i (.i_core_clk(clk),
    .i_nrst(nrst), .i_link_clk(lclk), .i_link_stop(stop), .i_link_rd_flags(rdf),
    .i_link_wr_ctrl(wrc), .i_link_mask(lmask), .i_link_pdown(pdn),
    .i_module_reset_in_n(rst_pin_n), .i_low_power_request(lp),
    .i_module_select_n(sel_n), .i_rx_los(cond[3:0]), .i_tx_fault(cond[7:4]),
    .i_other_flag(cond[11:8]), .o_interrupt_out_n_out(int_out),
    .o_interrupt_out_n_oe_n(oe_n), .o_data_not_ready(dnr), .o_flags(flags),
    .o_init_flag(init_f), .o_bus_respond(bus), .o_low_power(low_pw),
    .o_fully_functional(ff));

  // ----------------------------------------
  // Compare, wait and verdict
  // ----------------------------------------
  task automatic check_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic check_vec(input string name, input logic [NF-1:0] exp,
                           input logic [NF-1:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic clear_read();
    mstim_host_i.xfer(1'b1, 1'b0, 12'h000, 1'b0);
    cyc(5);
  endtask
  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Init count runs out: data ready, interrupt and bus come up together
  task automatic t_power_on();
    cyc(12);
    check_bit("dnr_early", 1'b1, dnr);
    check_bit("bus_early", 1'b0, bus);
    cyc(18);
    check_bit("dnr", 1'b0, dnr);
    check_bit("irq", 1'b0, oe_n);
    check_bit("init_flag", 1'b1, init_f);
    check_bit("bus", 1'b1, bus);
    check_bit("ff", 1'b1, ff);
    check_bit("int_val", 1'b0, int_out);
    clear_read();
    check_bit("irq_off", 1'b1, oe_n);
    check_bit("init_clr", 1'b0, init_f);
  endtask
  // Every flag source latches, raises the interrupt and clears on read
  task automatic t_flags();
    logic [NF-1:0] one;
    one = 12'h001;
    for (int i = 0; i < NF; i++) begin
      @(posedge clk) cond[i] <= 1'b1;
      cyc(5);
      check_bit("irq_src", 1'b0, oe_n);
      @(posedge clk) cond[i] <= 1'b0;
      cyc(5);
      check_vec("flags_held", one << i, flags);
      clear_read();
      check_vec("flags_clr", 12'h000, flags);
      check_bit("irq_clr", 1'b1, oe_n);
    end
  endtask
  // Masked source latches silently; unmasking resumes the interrupt
  task automatic t_mask();
    mstim_host_i.xfer(1'b0, 1'b1, 12'hfff, 1'b0);
    cyc(5);
    @(posedge clk) cond[0] <= 1'b1;
    cyc(5);
    check_vec("flags_masked", 12'h001, flags);
    check_bit("irq_masked", 1'b1, oe_n);
    mstim_host_i.xfer(1'b0, 1'b1, 12'h000, 1'b0);
    cyc(5);
    check_bit("irq_unmasked", 1'b0, oe_n);
    @(posedge clk) cond[0] <= 1'b0;
    cyc(2);
    clear_read();
    check_bit("irq_mclr", 1'b1, oe_n);
  endtask
  // Low-power pin and power-down bit
  task automatic t_power();
    @(posedge clk) lp <= 1'b1;
    cyc(5);
    check_bit("lp_pin", 1'b1, low_pw);
    @(posedge clk) lp <= 1'b0;
    cyc(5);
    check_bit("lp_pin_off", 1'b0, low_pw);
    mstim_host_i.xfer(1'b0, 1'b1, 12'h000, 1'b1);
    cyc(5);
    check_bit("pdown", 1'b1, low_pw);
    check_bit("pdown_ff", 1'b0, ff);
    mstim_host_i.xfer(1'b0, 1'b1, 12'h000, 1'b0);
    cyc(5);
    check_bit("pdown_off", 1'b0, low_pw);
    check_bit("ff_back", 1'b1, ff);
  endtask
  // Select gating of the bus engine
  task automatic t_select();
    @(posedge clk) sel_n <= 1'b1;
    cyc(5);
    check_bit("bus_desel", 1'b0, bus);
    @(posedge clk) sel_n <= 1'b0;
    cyc(5);
    check_bit("bus_sel", 1'b1, bus);
  endtask
  // Reset pin held over 2 us, then a full init again
  task automatic t_reset_pin();
    @(posedge clk) rst_pin_n <= 1'b0;
    cyc(250);
    check_bit("dnr_rst", 1'b1, dnr);
    check_bit("irq_rst", 1'b1, oe_n);
    check_bit("bus_rst", 1'b0, bus);
    @(posedge clk) rst_pin_n <= 1'b1;
    cyc(12);
    check_bit("dnr_wait", 1'b1, dnr);
    cyc(18);
    check_bit("dnr_rel", 1'b0, dnr);
    check_bit("ff_rel", 1'b1, ff);
    check_bit("irq_rel", 1'b0, oe_n);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_power_on();
    t_flags();
    t_mask();
    t_power();
    t_select();
    t_reset_pin();
    finish_test();
  end
  initial begin
    #200000;
    fails++;
    $display("BAD watchdog expected done seen hang");
    finish_test();
  end
endmodule
`default_nettype wire

/* mstim_defines.svh */
// Timing figures and field positions for the module status and interrupt block.
// Assumes a 100 MHz core clock; every cycle count is derived from the figures.
`ifndef MSTIM_DEFINES_SVH
`define MSTIM_DEFINES_SVH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define MSTIM_CLK_MHZ 100

// ----------------------------------------------------------------------------
// Time limits, in their own units
// ----------------------------------------------------------------------------
`define MSTIM_T_SERIAL_MS 2000
`define MSTIM_T_DATA_MS 2000
`define MSTIM_T_RESET_MS 2000
`define MSTIM_TON_LOWP_US 100
`define MSTIM_TON_INT_MS 200
`define MSTIM_TOFF_INT_US 500
`define MSTIM_TON_SEL_US 100
`define MSTIM_TOFF_SEL_US 100

// ----------------------------------------------------------------------------
// Derived cycle counts (longest times round down)
// ----------------------------------------------------------------------------
`define MSTIM_T_DATA_CYC (`MSTIM_T_DATA_MS * 1000 * `MSTIM_CLK_MHZ)
`define MSTIM_INIT_MARGIN 16
`define MSTIM_INIT_CYC (`MSTIM_T_DATA_CYC - `MSTIM_INIT_MARGIN)
`define MSTIM_TON_LOWP_CYC (`MSTIM_TON_LOWP_US * `MSTIM_CLK_MHZ)
`define MSTIM_TOFF_INT_CYC (`MSTIM_TOFF_INT_US * `MSTIM_CLK_MHZ)
`define MSTIM_TON_SEL_CYC (`MSTIM_TON_SEL_US * `MSTIM_CLK_MHZ)

// ----------------------------------------------------------------------------
// Flag vector layout
// ----------------------------------------------------------------------------
`define MSTIM_LANES 4
`define MSTIM_LOS_LSB 0
`define MSTIM_TXF_LSB 4
`define MSTIM_OTH_LSB 8
`define MSTIM_OTHER_FLAGS 4
`define MSTIM_DNR_BIT 0

`endif

/* mstim_host.sv */
// Host-side model of the two-wire bus end: link clock and finished transactions.
// Assumes mstim_core samples stop and the transaction kind on the falling link clock.
`timescale 1ns/10ps
`default_nettype none
module mstim_host #(
  parameter int NF = 12
) (
  output logic o_link_clk, // Bus clock, idles high
  output logic o_link_stop, // Stop seen
  output logic o_link_rd_flags, // Clearing read ended
  output logic o_link_wr_ctrl, // Control write ended
  output logic [NF-1:0] o_link_mask, // Mask word
  output logic o_link_pdown // Power-down bit
);
  // ----------------------------------------
  // Idle values and one falling edge inside reset
  // ----------------------------------------
  initial begin
    o_link_clk = 1'b1;
    o_link_stop = 1'b0;
    o_link_rd_flags = 1'b0;
    o_link_wr_ctrl = 1'b0;
    o_link_mask = '0;
    o_link_pdown = 1'b0;
    #3 o_link_clk = 1'b0;
    #80 o_link_clk = 1'b1;
  end

  // ----------------------------------------
  // One frame; the clock only runs inside it
  // ----------------------------------------
  task automatic xfer(input logic rd, input logic wr, input logic [NF-1:0] mask,
                      input logic pdown);
    #3;
    repeat (2) begin
      #80 o_link_clk = 1'b0;
      #80 o_link_clk = 1'b1;
    end
    // Stop and kind stand over the falling edge that ends the frame
    o_link_stop = 1'b1;
    o_link_rd_flags = rd;
    o_link_wr_ctrl = wr;
    o_link_mask = mask;
    o_link_pdown = pdown;
    #80 o_link_clk = 1'b0;
    #80 o_link_clk = 1'b1;
    // Released data no longer shows the last value
    o_link_stop = 1'b0;
    o_link_rd_flags = 1'b0;
    o_link_wr_ctrl = 1'b0;
    o_link_mask = ~mask;
    o_link_pdown = ~pdown;
  endtask
endmodule
`default_nettype wire

/* mstim_link.sv */
// Link-side capture of finished bus transactions, on the falling bus clock.
// Assumes the bus engine holds stop and the transaction kind for one falling edge.
`timescale 1ns/10ps
`default_nettype none
module mstim_link #(
  parameter int NF = 12
) (
  input wire logic i_link_clk, // Two-wire bus clock
  input wire logic i_nrst, // Async reset, active low
  input wire logic i_link_stop, // Stop bit seen
  input wire logic i_link_rd_flags, // Ended transaction read the flags
  input wire logic i_link_wr_ctrl, // Ended transaction wrote controls
  input wire logic [NF-1:0] i_link_mask, // Written mask bits
  input wire logic i_link_pdown, // Written power-down bit
  output logic o_rd_tgl, // Toggles per clearing read
  output logic o_wr_tgl, // Toggles per control write
  output logic [NF-1:0] o_mask, // Held mask bits
  output logic o_pdown // Held power-down bit
);
  typedef struct packed {
    logic rd_tgl;
    logic wr_tgl;
    logic [NF-1:0] mask;
    logic pdown;
  } mstim_link_s;

  mstim_link_s q, n;

  // Falling edge after stop starts the timing of reads and writes
  always_comb begin
    n = q;
    if (i_link_stop && i_link_rd_flags) begin
      n.rd_tgl = ~q.rd_tgl;
    end
    if (i_link_stop && i_link_wr_ctrl) begin
      n.mask = i_link_mask;
      n.pdown = i_link_pdown;
      n.wr_tgl = ~q.wr_tgl;
    end
  end

  // State register on the falling bus clock
  always_ff @(negedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign o_rd_tgl = q.rd_tgl;
  assign o_wr_tgl = q.wr_tgl;
  assign o_mask = q.mask;
  assign o_pdown = q.pdown;
endmodule
`default_nettype wire

/* mstim_pkg.sv */
// Types shared by the module status and interrupt block.
// Assumes mstim_defines.svh is included by the modules that need figures.
package mstim_pkg;

  // Main sequence states, one-hot
  typedef enum logic [2:0] {
    MSTIM_ST_RESET = 3'h1,
    MSTIM_ST_INIT = 3'h2,
    MSTIM_ST_RUN = 3'h4
  } mstim_state_e;

endpackage

/* mstim_sync.sv */
// Two-flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a level or a toggle that holds for several clocks.
`timescale 1ns/10ps
`default_nettype none
module mstim_sync #(
  parameter int W = 1
) (
  input wire logic i_clk, // Destination clock
  input wire logic i_nrst, // Async reset, active low
  input wire logic [W-1:0] i_d, // Asynchronous levels
  output logic [W-1:0] o_q // Synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mstim_sync_s;

  mstim_sync_s q, n;

  // First stage feeds only the second
  always_comb begin
    n = q;
    n.s1 = i_d;
    n.s2 = q.s1;
  end

  // State register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign o_q = q.s2;
endmodule
`default_nettype wire
